// >>> uart_channel_clock_select.sv
// Purpose: Per-channel rx and tx clock selection
// Assumes: All inputs synchronous to aclk; oscillator_input is sampled, not a clock
// Notes: Ticks are one-cycle pulses, so a source change never makes a runt clock
// Operation
// [RULE1] Upper select nibble picks receiver clock, lower nibble transmitter clock.
// [RULE2] Codes zero to twelve pick a standard generator rate.
// [RULE3] Thirteen picks timer, fourteen external 16X, fifteen external 1X.
// [RULE4] Rates follow four columns by rate-set and extend bit at 3.6864 MHz.
// [RULE5] At 7.3728 MHz the same columns give doubled rates.
// [RULE6] Top bit of the auxiliary control register selects the rate set.
// [RULE7] Each receiver and transmitter has an extend bit set only by commands.
// [RULE8] Command 08 sets receiver extend, 09 clears it.
// [RULE9] Command 0A sets transmitter extend, 0B clears it.
// [RULE10] Generator output ticks at sixteen times the bit rate.
// [RULE11] Generator rates scale with the actual oscillator frequency.
// [RULE12] Divided system clock mode halves every generator rate.
// [RULE13] With 16X clock, start bit midpoint is seven periods after detection.
// [RULE14] After the midpoint the receiver samples every sixteen 16X clocks.
// [RULE15] After the stop bit the receiver waits for the next start bit.
// [RULE16] With 1X clock the receiver samples once per supplied clock edge.
// [RULE17] Software should prefer 16X over 1X for any source.
// [RULE18] Remote sender must be synchronous to the clock when 1X is used.
// [RULE19] First auxiliary register governs channels A, B; second governs C, D.
// [RULE20] Timer output is treated as 16X and divided by sixteen.
// [RULE21] Input pins serve as external clock inputs for codes fourteen, fifteen.
// [RULE22] Clock select writes change source without a runt pulse.
//
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
`timescale 1ns/100ps

module rate_source
    import uart_clock_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Selection
    input wire logic [3:0] nibble,
    input wire logic rate_set,
    input wire logic extend,
    input wire logic divided,
    // Source edges
    input wire logic osc_rise,
    input wire logic timer_rise,
    input wire logic ext_rise,
    // Ticks
    output logic tick16,
    output logic bit_tick,
    output logic mode_1x
);
    logic [14:0] divisor, limit, count;
    logic [3:0] sub;
    logic next_tick16;
    logic [1:0] col;

    assign col = {rate_set, extend};

    always_comb begin
        case (nibble)
            4'h0: divisor = (col == 2'h0 || col == 2'h3) ? DIV_50 : DIV_75;
            4'h1: divisor = DIV_110;
            4'h2: divisor = DIV_134;
            4'h3: divisor = (col == 2'h0 || col == 2'h3) ? DIV_200 : DIV_150;
            4'h4: divisor = extend ? DIV_3600 : DIV_300;
            4'h5: divisor = extend ? DIV_14K4 : DIV_600;
            4'h6: divisor = extend ? DIV_28K8 : DIV_1200;
            4'h7: divisor = extend ? DIV_57K6 : (rate_set ? DIV_2000 : DIV_1050);
            4'h8: divisor = extend ? DIV_115K2 : DIV_2400;
            4'h9: divisor = DIV_4800;
            4'ha: divisor = (col == 2'h0 || col == 2'h3) ? DIV_7200 : DIV_1800;
            4'hb: divisor = DIV_9600;
            4'hc: divisor = (col == 2'h0 || col == 2'h3) ? DIV_38K4 : DIV_19K2;
            default: divisor = DIV_9600;
        endcase
    end // RULE2 RULE4 RULE5 RULE6

    // Rates are oscillator divisions, so they track its frequency
    assign limit = (divided ? {divisor[13:0], 1'b0} : divisor) - 15'h0001; // RULE12 RULE11

    always_comb begin
        case (nibble)
            SEL_TIMER: next_tick16 = timer_rise; // RULE20
            SEL_EXT_16X: next_tick16 = ext_rise; // RULE3 RULE21
            SEL_EXT_1X: next_tick16 = 1'b0;
            default: next_tick16 = osc_rise && (count >= limit); // RULE10
        endcase
    end

    // Counter restarts from any count at or above the limit, so a smaller divisor never stalls it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= 15'h0000;
        end else if (osc_rise) begin
            count <= (count >= limit) ? 15'h0000 : count + 15'h0001; // RULE22
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sub <= 4'h0;
        end else if (nibble == SEL_EXT_1X) begin
            sub <= 4'h0;
        end else if (next_tick16) begin
            sub <= sub + 4'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {tick16, bit_tick, mode_1x} <= 3'h0;
        end else begin
            tick16 <= next_tick16;
            mode_1x <= (nibble == SEL_EXT_1X); // RULE3
            bit_tick <= (nibble == SEL_EXT_1X) ? ext_rise // RULE16
                : next_tick16 && (sub == BIT_LAST_COUNT); // RULE20
        end
    end
endmodule

module serial_receiver
    import uart_clock_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Timing
    input wire logic tick16,
    input wire logic bit_tick,
    input wire logic mode_1x,
    // Line
    input wire logic rx_line,
    // Character out
    output logic [7:0] data,
    output logic frame_err,
    output logic done
);
    rx_state_t state;
    logic [3:0] phase, bits;
    logic [7:0] shift;
    logic sample;

    // 16X: one sample per sixteen ticks; 1X: one per supplied edge
    assign sample = mode_1x ? bit_tick : (tick16 && phase == BIT_LAST_COUNT); // RULE14 RULE16

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= RX_IDLE;
            {phase, bits, shift, data, frame_err, done} <= '0;
        end else begin
            done <= 1'b0;
            if (tick16 && state != RX_IDLE) begin
                phase <= phase + 4'h1;
            end
            case (state)
                RX_IDLE: begin
                    bits <= 4'h0;
                    phase <= 4'h0;
                    if (mode_1x && bit_tick && !rx_line) begin
                        state <= RX_DATA; // RULE16
                    end else if (!mode_1x && tick16 && !rx_line) begin
                        state <= RX_START; // RULE13
                    end
                end
                RX_START: begin
                    if (mode_1x) begin
                        state <= RX_IDLE;
                    end else if (tick16 && phase == START_MID_COUNT - 4'h1) begin
                        // Glitches over by the seventh 16X tick after detection are dropped here
                        phase <= 4'h0;
                        state <= rx_line ? RX_IDLE : RX_DATA; // RULE13
                    end
                end
                RX_DATA: begin
                    if (sample) begin
                        shift <= {rx_line, shift[7:1]};
                        bits <= bits + 4'h1;
                        if (bits == DATA_BITS - 4'h1) begin
                            state <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (sample) begin
                        data <= shift;
                        frame_err <= !rx_line;
                        done <= 1'b1;
                        state <= RX_IDLE; // RULE15
                    end
                end
                default: state <= RX_IDLE;
            endcase
        end
    end
endmodule

module uart_channel_clock_select
    import uart_clock_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Timing sources
    input wire logic oscillator_input,
    input wire logic timer_out_ab,
    input wire logic timer_out_cd,
    input wire logic [3:0] ext_rx_clock,
    input wire logic [3:0] ext_tx_clock,
    // Serial lines
    input wire logic [3:0] rx_serial,
    // Transmitter timing
    output logic [3:0] tx_clock16_tick,
    output logic [3:0] tx_bit_tick
);
    logic [7:0] clock_select [0:3];
    logic [7:0] rx_data [0:3];
    logic [7:0] rx_char [0:3];
    logic [7:0] aux_control_pair_ab, aux_control_pair_cd, w_byte;
    logic [ADDR_W-1:0] aw_addr, cmd_off;
    logic [3:0] rx_extend, tx_extend, rx_err, rx_full, rx_done, rx_tick16, rx_bit, rx_1x;
    logic [3:0] rx_char_err, ext_rx_prev, ext_tx_prev, rd_clear;
    logic [1:0] timer_prev, rd_idx;
    logic divided_mode, osc_prev, aw_held, w_held, w_lane, do_write, next_rerr;
    logic [31:0] next_rdata;

    // Edge detection on synchronous inputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {osc_prev, timer_prev, ext_rx_prev, ext_tx_prev} <= 11'h000;
        end else begin
            {osc_prev, timer_prev, ext_rx_prev, ext_tx_prev} <=
                {oscillator_input, timer_out_cd, timer_out_ab, ext_rx_clock, ext_tx_clock};
        end
    end

    // Write channel: address and data taken in either order
    assign awready = !aw_held && !bvalid;
    assign wready = !w_held && !bvalid;
    assign do_write = aw_held && w_held && !bvalid;
    assign bresp = 2'b00;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {aw_held, w_held, aw_addr, w_byte, w_lane, bvalid} <= '0;
        end else begin
            if (awvalid && awready) begin
                aw_held <= 1'b1;
                aw_addr <= awaddr;
            end
            if (wvalid && wready) begin
                w_held <= 1'b1;
                w_byte <= wdata[7:0];
                w_lane <= wstrb[0];
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                bvalid <= 1'b1;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clock_select <= '{default: CLOCK_SELECT_RESET};
            aux_control_pair_ab <= AUX_CONTROL_RESET;
            aux_control_pair_cd <= AUX_CONTROL_RESET;
            divided_mode <= 1'b0;
        end else if (do_write && w_lane) begin
            case (aw_addr)
                OFS_CLOCK_SELECT_A: clock_select[0] <= w_byte;
                OFS_CLOCK_SELECT_B: clock_select[1] <= w_byte;
                OFS_CLOCK_SELECT_C: clock_select[2] <= w_byte;
                OFS_CLOCK_SELECT_D: clock_select[3] <= w_byte;
                OFS_AUX_CONTROL_AB: aux_control_pair_ab <= w_byte; // RULE6
                OFS_AUX_CONTROL_CD: aux_control_pair_cd <= w_byte; // RULE6
                OFS_MODE: divided_mode <= w_byte[MODE_DIVIDED_BIT];
                default: divided_mode <= divided_mode;
            endcase
        end
    end

    assign cmd_off = aw_addr - OFS_COMMAND_A;

    // Extend bits change only through command writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_extend <= 4'h0;
            tx_extend <= 4'h0;
        end else if (do_write && w_lane && aw_addr >= OFS_COMMAND_A && aw_addr <= OFS_COMMAND_D
                && aw_addr[1:0] == 2'b00) begin
            case (w_byte)
                CMD_SET_RX_EXTEND: rx_extend[cmd_off[3:2]] <= 1'b1; // RULE8
                CMD_CLEAR_RX_EXTEND: rx_extend[cmd_off[3:2]] <= 1'b0; // RULE8
                CMD_SET_TX_EXTEND: tx_extend[cmd_off[3:2]] <= 1'b1; // RULE9
                CMD_CLEAR_TX_EXTEND: tx_extend[cmd_off[3:2]] <= 1'b0; // RULE9
                default: rx_extend <= rx_extend;
            endcase // RULE7
        end
    end

    // Eight timing sources, one per direction of each channel
    for (genvar c = 0; c < 4; c++) begin : g_chan
        logic rate_set;
        logic timer_rise;
        assign rate_set = (c < 2) ? aux_control_pair_ab[RATE_SET_BIT] // RULE19
            : aux_control_pair_cd[RATE_SET_BIT];
        assign timer_rise = (c < 2) ? timer_out_ab && !timer_prev[0]
            : timer_out_cd && !timer_prev[1];
        rate_source u_rx_rate (.aclk(aclk), .aresetn(aresetn),
            .nibble(clock_select[c][7:4]), .rate_set(rate_set), .extend(rx_extend[c]), // RULE1
            .divided(divided_mode), .osc_rise(oscillator_input && !osc_prev),
            .timer_rise(timer_rise), .ext_rise(ext_rx_clock[c] && !ext_rx_prev[c]), // RULE21
            .tick16(rx_tick16[c]), .bit_tick(rx_bit[c]), .mode_1x(rx_1x[c]));
        rate_source u_tx_rate (.aclk(aclk), .aresetn(aresetn),
            .nibble(clock_select[c][3:0]), .rate_set(rate_set), .extend(tx_extend[c]), // RULE1
            .divided(divided_mode), .osc_rise(oscillator_input && !osc_prev),
            .timer_rise(timer_rise), .ext_rise(ext_tx_clock[c] && !ext_tx_prev[c]), // RULE21
            .tick16(tx_clock16_tick[c]), .bit_tick(tx_bit_tick[c]), .mode_1x());
        serial_receiver u_rx (.aclk(aclk), .aresetn(aresetn), .tick16(rx_tick16[c]),
            .bit_tick(rx_bit[c]), .mode_1x(rx_1x[c]), .rx_line(rx_serial[c]),
            .data(rx_char[c]), .frame_err(rx_char_err[c]), .done(rx_done[c]));
    end

    // Holding register per channel; a new character wins over a read clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_data <= '{default: 8'h00};
            {rx_err, rx_full} <= 8'h00;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (rx_done[i]) begin
                    rx_data[i] <= rx_char[i];
                    rx_err[i] <= rx_char_err[i];
                    rx_full[i] <= 1'b1;
                end else if (rd_clear[i]) begin
                    rx_full[i] <= 1'b0;
                end
            end
        end
    end

    // Read channel
    assign arready = !rvalid;
    assign rd_idx = araddr[3:2];

    always_comb begin
        next_rdata = 32'h00000000;
        next_rerr = 1'b0;
        rd_clear = 4'h0;
        if (araddr == OFS_AUX_CONTROL_AB) begin
            next_rdata[7:0] = aux_control_pair_ab;
        end else if (araddr == OFS_AUX_CONTROL_CD) begin
            next_rdata[7:0] = aux_control_pair_cd;
        end else if (araddr == OFS_MODE) begin
            next_rdata[MODE_DIVIDED_BIT] = divided_mode;
        end else if (araddr == OFS_EXTEND_STATUS) begin
            next_rdata[7:0] = {tx_extend, rx_extend};
        end else if (araddr >= OFS_RX_DATA_A && araddr <= OFS_RX_DATA_D
                && araddr[1:0] == 2'b00) begin
            next_rdata[7:0] = rx_data[rd_idx];
            next_rdata[RX_FRAME_ERR_BIT] = rx_err[rd_idx];
            next_rdata[RX_FULL_BIT] = rx_full[rd_idx];
            rd_clear[rd_idx] = arvalid && arready;
        end else if (araddr > OFS_COMMAND_D || araddr[1:0] != 2'b00) begin
            next_rerr = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {rvalid, rdata, rresp} <= 35'h0;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= next_rdata;
            rresp <= next_rerr ? 2'b10 : 2'b00;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end
endmodule

// >>> uart_clock_pkg.sv
// Purpose: Shared constants for the channel clock select block
// Assumes: 8-bit byte address on the register bus, 32-bit data words
// Notes: Generator divisors count oscillator edges per 16X tick
package uart_clock_pkg;

    localparam int ADDR_W = 8;

    // Register byte offsets
    localparam logic [7:0] OFS_CLOCK_SELECT_A = 8'h00;
    localparam logic [7:0] OFS_CLOCK_SELECT_B = 8'h04;
    localparam logic [7:0] OFS_CLOCK_SELECT_C = 8'h08;
    localparam logic [7:0] OFS_CLOCK_SELECT_D = 8'h0c;
    localparam logic [7:0] OFS_AUX_CONTROL_AB = 8'h10;
    localparam logic [7:0] OFS_AUX_CONTROL_CD = 8'h14;
    localparam logic [7:0] OFS_COMMAND_A = 8'h18;
    localparam logic [7:0] OFS_COMMAND_B = 8'h1c;
    localparam logic [7:0] OFS_COMMAND_C = 8'h20;
    localparam logic [7:0] OFS_COMMAND_D = 8'h24;
    localparam logic [7:0] OFS_MODE = 8'h28;
    localparam logic [7:0] OFS_EXTEND_STATUS = 8'h2c;
    localparam logic [7:0] OFS_RX_DATA_A = 8'h30;
    localparam logic [7:0] OFS_RX_DATA_D = 8'h3c;

    // Field positions and reset values
    localparam int RATE_SET_BIT = 7;
    localparam int MODE_DIVIDED_BIT = 0;
    localparam int RX_FRAME_ERR_BIT = 8;
    localparam int RX_FULL_BIT = 9;
    localparam logic [7:0] CLOCK_SELECT_RESET = 8'h00;
    localparam logic [7:0] AUX_CONTROL_RESET = 8'h00;

    // Command codes
    localparam logic [7:0] CMD_SET_RX_EXTEND = 8'h08;
    localparam logic [7:0] CMD_CLEAR_RX_EXTEND = 8'h09;
    localparam logic [7:0] CMD_SET_TX_EXTEND = 8'h0a;
    localparam logic [7:0] CMD_CLEAR_TX_EXTEND = 8'h0b;

    // Clock select nibble codes
    localparam logic [3:0] SEL_LAST_STANDARD = 4'hc;
    localparam logic [3:0] SEL_TIMER = 4'hd;
    localparam logic [3:0] SEL_EXT_16X = 4'he;
    localparam logic [3:0] SEL_EXT_1X = 4'hf;

    // Oscillator edges per 16X tick for each standard rate
    localparam logic [14:0] DIV_50 = 15'h1200;
    localparam logic [14:0] DIV_75 = 15'h0c00;
    localparam logic [14:0] DIV_110 = 15'h082f;
    localparam logic [14:0] DIV_134 = 15'h06b1;
    localparam logic [14:0] DIV_150 = 15'h0600;
    localparam logic [14:0] DIV_200 = 15'h0480;
    localparam logic [14:0] DIV_300 = 15'h0300;
    localparam logic [14:0] DIV_600 = 15'h0180;
    localparam logic [14:0] DIV_1050 = 15'h00db;
    localparam logic [14:0] DIV_1200 = 15'h00c0;
    localparam logic [14:0] DIV_1800 = 15'h0080;
    localparam logic [14:0] DIV_2000 = 15'h0073;
    localparam logic [14:0] DIV_2400 = 15'h0060;
    localparam logic [14:0] DIV_3600 = 15'h0040;
    localparam logic [14:0] DIV_4800 = 15'h0030;
    localparam logic [14:0] DIV_7200 = 15'h0020;
    localparam logic [14:0] DIV_9600 = 15'h0018;
    localparam logic [14:0] DIV_14K4 = 15'h0010;
    localparam logic [14:0] DIV_19K2 = 15'h000c;
    localparam logic [14:0] DIV_28K8 = 15'h0008;
    localparam logic [14:0] DIV_38K4 = 15'h0006;
    localparam logic [14:0] DIV_57K6 = 15'h0004;
    localparam logic [14:0] DIV_115K2 = 15'h0002;

    // Receiver timing in 16X periods
    localparam logic [3:0] START_MID_COUNT = 4'h7;
    localparam logic [3:0] BIT_LAST_COUNT = 4'hf;
    localparam logic [3:0] DATA_BITS = 4'h8;

    typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

endpackage

// >>> clock_select_asserts.sv
// Purpose: Bus handshake checks on the clock select block
// Assumes: Sees only the top module ports
// Notes: Tick rates are judged by the bench, which knows the selection
`timescale 1ns/100ps
module clock_select_asserts (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write side
    input wire logic awvalid, input wire logic awready, input wire logic wvalid,
    input wire logic wready, input wire logic [1:0] bresp, input wire logic bvalid,
    input wire logic bready,
    // Read side
    input wire logic arvalid, input wire logic arready, input wire logic [31:0] rdata,
    input wire logic [1:0] rresp, input wire logic rvalid, input wire logic rready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_wr_ans; awvalid && awready && wvalid && wready |=> ##1 bvalid; endproperty
    a_wr_ans: assert property (p_wr_ans) else $error("write not answered");
    property p_b_hold; bvalid && !bready |=> bvalid; endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    property p_b_block; bvalid |-> !awready && !wready; endproperty
    a_b_block: assert property (p_b_block) else $error("write taken early");
    property p_bresp; bvalid |-> bresp == 2'b00; endproperty
    a_bresp: assert property (p_bresp) else $error("write answer not okay");
    property p_rd_ans; arvalid && arready |=> rvalid; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
    property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer moved");
    property p_ar_block; rvalid |-> !arready; endproperty
    a_ar_block: assert property (p_ar_block) else $error("read taken early");
    property p_r_free; rvalid && rready |=> !rvalid && arready; endproperty
    a_r_free: assert property (p_r_free) else $error("read answer stuck");
endmodule

bind uart_channel_clock_select clock_select_asserts i_chk (.aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));

// >>> serial_sender.sv
// Purpose: Remote serial transmitter, 8 data bits LSB first, one stop bit
// Assumes: Bit period is a whole number of aclk cycles
// Notes: Stop level is a knob so a framing fault can be commanded
`timescale 1ns/100ps
module serial_sender #(parameter int BIT_CYC = 64) (
    // Clock
    input wire logic aclk,
    // Request
    input wire logic send,
    input wire logic [7:0] din,
    input wire logic stop_lvl,
    // Line
    output logic line,
    output logic busy
);
    logic [9:0] sh;
    int cnt;
    int nb;
    initial begin
        line = 1'b1;
        busy = 1'b0;
    end
    // Runs on aclk like the receiver, so there is no drift against it
    always @(posedge aclk) begin
        if (!busy && send) begin
            sh <= {stop_lvl, din, 1'b0};
            busy <= 1'b1;
            cnt <= 0;
            nb <= 0;
            line <= 1'b0;
        end else if (busy) begin
            cnt <= (cnt == BIT_CYC - 1) ? 0 : cnt + 1;
            if (cnt == BIT_CYC - 1) begin
                nb <= nb + 1;
                busy <= (nb != 9);
                line <= (nb == 9) ? 1'b1 : sh[nb+1];
            end
        end
    end
endmodule

// >>> uart_channel_clock_select_test.sv
// Purpose: Self-checking bench for the channel clock select block
// Assumes: Oscillator toggles every aclk, timer period 8, external period 6
// Notes: Expected generator 16X tick gaps are twice the divisor in aclk cycles, four times in divided mode
`timescale 1ns/100ps
module uart_channel_clock_select_test;
    import uart_clock_pkg::*;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 0, araddr = 0, din = 0;
    logic [31:0] wdata = 0, rdata;
    logic [3:0] wstrb = 0, tx_clock16_tick, tx_bit_tick;
    logic awready, wready, bvalid, arready, rvalid, line, busy;
    logic [1:0] bresp, rresp;
    logic oscillator_input = 0, timer = 0, ext = 0, send = 0, stop_lvl = 1;
    int n_errors = 0, tests_run = 0, cyc = 0;
    uart_channel_clock_select i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .oscillator_input(oscillator_input), .timer_out_ab(timer),
        .timer_out_cd(timer), .ext_rx_clock({4{ext}}), .ext_tx_clock({4{ext}}),
        .rx_serial({3'b111, line}), .tx_clock16_tick(tx_clock16_tick), .tx_bit_tick(tx_bit_tick));
    serial_sender i_far (.aclk(aclk), .send(send), .din(din), .stop_lvl(stop_lvl), .line(line),
        .busy(busy));
    initial forever #20 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        oscillator_input <= ~oscillator_input;
        timer <= cyc[2];
        ext <= (cyc % 6) < 3;
        if (cyc == 20000) begin
            n_errors++;
            close_out;
        end
    end
    task automatic close_out;
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [7:0] d);
        logic ha, hw, dn;
        dn = 0;
        @(posedge aclk);
        {awaddr, wdata, wstrb} <= {a, 24'h0, d, 4'hf};
        {awvalid, wvalid, bready} <= 3'b111;
        while (!dn) begin
            @(negedge aclk);
            {ha, hw, dn} = {awvalid && awready, wvalid && wready, bvalid};
            @(posedge aclk);
            if (ha) awvalid <= 0;
            if (hw) wvalid <= 0;
        end
        bready <= 0;
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ha, dn;
        dn = 0;
        @(posedge aclk);
        {araddr, arvalid, rready} <= {a, 2'b11};
        while (!dn) begin
            @(negedge aclk);
            {ha, dn, d, r} = {arvalid && arready, rvalid, rdata, rresp};
            @(posedge aclk);
            if (ha) arvalid <= 0;
        end
        rready <= 0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] d;
        logic [1:0] r;
        axr(a, d, r);
        chk(what, exp, d);
    endtask
    task automatic gap(input int w, output int g);
        int n, last;
        {n, last, g} = 0;
        for (int i = 0; i < 4000 && n < 3; i++) begin
            @(negedge aclk);
            if ((w ? tx_bit_tick[0] : tx_clock16_tick[0]) === 1'b1) begin
                n++;
                if (n == 3) g = i - last;
                last = i;
            end
        end
    endtask
    task automatic t_regs;
        logic [31:0] d;
        logic [1:0] r;
        axw(OFS_AUX_CONTROL_CD, 8'h80);
        rdchk(OFS_AUX_CONTROL_CD, 32'h80, "aux cd");
        rdchk(OFS_AUX_CONTROL_AB, 32'h0, "aux ab");
        axw(OFS_COMMAND_A, CMD_SET_RX_EXTEND);
        axw(OFS_COMMAND_A, CMD_SET_TX_EXTEND);
        axw(OFS_COMMAND_C, CMD_SET_TX_EXTEND);
        rdchk(OFS_EXTEND_STATUS, 32'h51, "extend set");
        axw(OFS_COMMAND_A, CMD_CLEAR_RX_EXTEND);
        axw(OFS_COMMAND_A, CMD_CLEAR_TX_EXTEND);
        axw(OFS_EXTEND_STATUS, 8'hff);
        rdchk(OFS_EXTEND_STATUS, 32'h40, "extend clear");
        rdchk(OFS_CLOCK_SELECT_A, 32'h0, "select read");
        axr(8'h40, d, r);
        chk("unmapped resp", 32'(2'b10), 32'(r));
        axw(OFS_AUX_CONTROL_CD, 8'h00);
    endtask
    // Code, aux, command, mode, pulse kind, expected gap
    int tab [10][6] = '{'{12, 0, 11, 0, 0, 12}, '{12, 0, 10, 0, 0, 24}, '{8, 128, 10, 0, 0, 4},
        '{8, 128, 11, 0, 0, 192}, '{4, 0, 10, 0, 0, 128}, '{8, 128, 10, 1, 0, 8},
        '{8, 128, 10, 0, 1, 64}, '{13, 0, 11, 0, 0, 8}, '{14, 0, 11, 0, 0, 6},
        '{15, 0, 11, 0, 1, 6}};
    task automatic t_rates;
        int g;
        for (int i = 0; i < 10; i++) begin
            axw(OFS_MODE, 8'(tab[i][3]));
            axw(OFS_AUX_CONTROL_AB, 8'(tab[i][1]));
            axw(OFS_COMMAND_A, 8'(tab[i][2]));
            axw(OFS_CLOCK_SELECT_A, {4'h5, 4'(tab[i][0])});
            gap(tab[i][4], g);
            chk("tick gap", tab[i][5], g);
        end
    endtask
    task automatic sendc(input logic [7:0] d, input logic s);
        @(posedge aclk);
        {din, stop_lvl, send} <= {d, s, 1'b1};
        @(posedge aclk);
        send <= 0;
    endtask
    task automatic waitc;
        @(negedge aclk);
        while (busy) @(negedge aclk);
    endtask
    task automatic t_receive;
        axw(OFS_MODE, 8'h00);
        axw(OFS_AUX_CONTROL_AB, 8'h80);
        axw(OFS_COMMAND_A, CMD_SET_RX_EXTEND);
        axw(OFS_CLOCK_SELECT_A, 8'h8c);
        sendc(8'ha5, 1);
        waitc;
        sendc(8'h3c, 1);
        rdchk(OFS_RX_DATA_A, 32'h2a5, "rx first");
        waitc;
        rdchk(OFS_RX_DATA_A, 32'h23c, "rx second");
        rdchk(OFS_RX_DATA_A, 32'h03c, "rx drained");
        sendc(8'h0f, 0);
        waitc;
        rdchk(OFS_RX_DATA_A, 32'h30f, "rx bad stop");
    endtask
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1;
        t_regs;
        t_rates;
        t_receive;
        close_out;
    end
endmodule
